// ### lpcb_defs.svh
`ifndef LPCB_DEFS_SVH
`define LPCB_DEFS_SVH
// timing figures in ns or in clocks, cycle counts derived at 5 ns per core_clk
`define LPCB_CLK_PS        5000
`define LPCB_TRCD_NS       18
`define LPCB_TRP_NS        18
`define LPCB_TRRD_NS       10
`define LPCB_TMRR_CK       2
`define LPCB_TMRW_CK       5
`define LPCB_TRFC_NS       130
`define LPCB_TXP_NS        8
`define LPCB_BURST_CK      4
`define LPCB_CYC_UP(ns)    (((ns) * 1000 + `LPCB_CLK_PS - 1) / `LPCB_CLK_PS)
`define LPCB_CNT_W         8
`define LPCB_NBANK         8
`endif

// ### lpcb_pkg.sv
package lpcb_pkg;
    typedef enum logic [3:0] {
        LPCB_NOP = 4'h0, LPCB_ACT = 4'h1, LPCB_RD = 4'h2, LPCB_WR = 4'h3,
        LPCB_PRE = 4'h4, LPCB_PREA = 4'h5, LPCB_BST = 4'h6, LPCB_MRR = 4'h7,
        LPCB_MRW = 4'h8, LPCB_REF = 4'h9, LPCB_RST = 4'ha, LPCB_SRE = 4'hb
    } lpcb_cmd_t;
    typedef enum logic [2:0] {
        LPCB_B_IDLE = 3'h0, LPCB_B_OPEN = 3'h1, LPCB_B_ACTV = 3'h3,
        LPCB_B_BURST = 3'h2, LPCB_B_PRE = 3'h6
    } lpcb_bank_t;
    typedef struct packed {
        lpcb_cmd_t   cmd;
        logic [2:0]  bank;
        logic        auto_pre;
        logic [14:0] row;
        logic [9:0]  col;
        logic [7:0]  mr_addr;
        logic [7:0]  mr_data;
    } lpcb_req_t;
    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  mask;
    } lpcb_wbeat_t;
endpackage : lpcb_pkg

// ### lpcb_bank.sv
`timescale 1ns/1ps
`include "lpcb_defs.svh"
module lpcb_bank
    import lpcb_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  wire logic       hit,
    input  lpcb_pkg::lpcb_cmd_t  cmd,
    input  wire logic            auto_pre,
    output lpcb_pkg::lpcb_bank_t state
);
    import lpcb_pkg::*;
    localparam logic [7:0] TRCD_C  = 8'(`LPCB_CYC_UP(`LPCB_TRCD_NS));
    localparam logic [7:0] TRP_C   = 8'(`LPCB_CYC_UP(`LPCB_TRP_NS));
    localparam logic [7:0] BURST_C = 8'(`LPCB_BURST_CK);
    lpcb_bank_t state_r, state_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic       ap_r, ap_nxt;
    assign state = state_r;
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r != 8'h0) ? cnt_r - 8'h1 : 8'h0;
        ap_nxt    = ap_r;
        // a mode register read must not stall a bank that is mid-transition
        if (hit && cmd != LPCB_MRR)
        begin
            case (cmd)
                LPCB_ACT:
                begin
                    state_nxt = LPCB_B_OPEN;
                    cnt_nxt   = TRCD_C;
                end
                LPCB_RD, LPCB_WR:
                begin
                    state_nxt = LPCB_B_BURST;
                    cnt_nxt   = BURST_C;
                    ap_nxt    = auto_pre;
                end
                LPCB_PRE, LPCB_PREA:
                begin
                    state_nxt = LPCB_B_PRE;
                    cnt_nxt   = TRP_C;
                end
                LPCB_BST:
                    state_nxt = LPCB_B_ACTV;
                default:
                    state_nxt = state_r;
            endcase
        end
        else if (cnt_r <= 8'h1)
        begin
            // settling continues even across a mode register read
            case (state_r)
                LPCB_B_OPEN:  state_nxt = LPCB_B_ACTV;
                LPCB_B_PRE:   state_nxt = LPCB_B_IDLE;
                LPCB_B_BURST:
                begin
                    state_nxt = ap_r ? LPCB_B_PRE : LPCB_B_ACTV;
                    cnt_nxt   = ap_r ? TRP_C : 8'h0;
                end
                default:      state_nxt = state_r;
            endcase
        end
    end
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= LPCB_B_IDLE;
            cnt_r   <= 8'h0;
            ap_r    <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            ap_r    <= ap_nxt;
        end
    end
endmodule : lpcb_bank

// ### lpcb_ctrl.sv
`timescale 1ns/1ps
`include "lpcb_defs.svh"
module lpcb_ctrl
    import lpcb_pkg::*;
#(
    parameter int NBANK = `LPCB_NBANK
)
(
    input  wire logic            core_clk,
    input  wire logic            arst_n,
    input  lpcb_pkg::lpcb_req_t  req,
    input  wire logic            req_valid,
    output logic                 req_ready,
    output logic                 req_illegal,
    input  lpcb_pkg::lpcb_wbeat_t wbeat,
    input  wire logic            pd_exit,
    output lpcb_pkg::lpcb_cmd_t  mem_cmd,
    output logic [2:0]           mem_bank,
    output logic                 mem_auto_pre,
    output logic [14:0]          mem_row,
    output logic [9:0]           mem_col,
    output logic [15:0]          mem_mr,
    output logic                 mem_cke,
    output logic [31:0]          mem_dq_o,
    output logic [3:0]           mem_dm
);
    import lpcb_pkg::*;
    localparam logic [7:0] TRRD_C = 8'(`LPCB_CYC_UP(`LPCB_TRRD_NS));
    localparam logic [7:0] TMRR_C = 8'(`LPCB_TMRR_CK);
    localparam logic [7:0] TMRW_C = 8'(`LPCB_TMRW_CK);
    localparam logic [7:0] TRFC_C = 8'(`LPCB_CYC_UP(`LPCB_TRFC_NS));
    localparam logic [7:0] TXP_C  = 8'(`LPCB_CYC_UP(`LPCB_TXP_NS));

    lpcb_bank_t bst [NBANK];
    logic [NBANK-1:0] idle_v, burst_v, prev_ok_v;
    logic [7:0]  busy_r, busy_nxt, rrd_r, rrd_nxt;
    logic [2:0]  last_bank_r;
    logic        bursting_r, resetting_r, last_wr_r;
    logic        take, legal;
    logic        pd_s1_r, pd_s2_r, pd_s3_r;

    genvar g;
    generate
        for (g = 0; g < NBANK; g++)
        begin : g_bank
            lpcb_bank u_bank (
                .core_clk (core_clk),
                .arst_n   (arst_n),
                .hit      (take && (req.bank == 3'(g) || req.cmd == LPCB_PREA)),
                .cmd      (req.cmd),
                .auto_pre (req.auto_pre),
                .state    (bst[g])
            );
            assign idle_v[g]    = bst[g] == LPCB_B_IDLE;
            assign burst_v[g]   = bst[g] == LPCB_B_BURST;
            assign prev_ok_v[g] = bst[g] != LPCB_B_BURST;
        end
    endgenerate

    wire lpcb_bank_t tgt      = bst[req.bank];
    wire logic       all_idle = &idle_v;
    wire logic       any_burst = |burst_v;
    // a single busy timer covers MRR, MRW, refresh and power-down exit
    wire logic       quiet    = busy_r == 8'h0;

    function automatic logic cmd_legal(input lpcb_cmd_t c, input lpcb_bank_t t);
        case (c)
            LPCB_ACT:  cmd_legal = t == LPCB_B_IDLE && rrd_r == 8'h0;
            // a write waits out any read burst, and a read any write burst
            LPCB_RD:   cmd_legal = t == LPCB_B_ACTV && !(any_burst && last_wr_r);
            LPCB_WR:   cmd_legal = t == LPCB_B_ACTV && !(any_burst && !last_wr_r);
            LPCB_PRE:  cmd_legal = t != LPCB_B_BURST;
            LPCB_PREA: cmd_legal = &prev_ok_v;
            LPCB_BST:  cmd_legal = bursting_r && t == LPCB_B_BURST
                                   && req.bank == last_bank_r;
            LPCB_MRR:  cmd_legal = !any_burst;
            LPCB_MRW,
            LPCB_REF,
            LPCB_SRE,
            LPCB_RST:  cmd_legal = all_idle;
            LPCB_NOP:  cmd_legal = 1'b1;
            default:   cmd_legal = 1'b0;
        endcase
    endfunction : cmd_legal

    // a process, not an assign, so the timers and flags read inside the function wake it
    always_comb
    begin
        legal = cmd_legal(req.cmd, tgt);
    end
    assign req_ready   = quiet && legal && pd_s2_r && pd_s3_r;
    assign take        = req_valid && req_ready && req.cmd != LPCB_NOP;
    assign req_illegal = req_valid && quiet && pd_s2_r && pd_s3_r && !legal;

    always_comb
    begin
        busy_nxt = (busy_r != 8'h0) ? busy_r - 8'h1 : 8'h0;
        rrd_nxt  = (rrd_r != 8'h0) ? rrd_r - 8'h1 : 8'h0;
        // exit timer starts off the settled stage, never the first flop
        if (pd_s2_r && !pd_s3_r)
            busy_nxt = TXP_C;
        if (take)
        begin
            case (req.cmd)
                LPCB_MRR: busy_nxt = TMRR_C;
                LPCB_MRW,
                LPCB_RST: busy_nxt = TMRW_C;
                LPCB_REF: busy_nxt = TRFC_C;
                LPCB_ACT: rrd_nxt  = TRRD_C;
                default:  busy_nxt = busy_nxt;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy_r <= 8'h0;
            rrd_r  <= 8'h0;
            pd_s1_r <= 1'b0;
            pd_s2_r <= 1'b0;
            pd_s3_r <= 1'b0;
        end
        else
        begin
            busy_r  <= busy_nxt;
            rrd_r   <= rrd_nxt;
            // pd_exit high means clock enable restored
            pd_s1_r <= pd_exit;
            pd_s2_r <= pd_s1_r;
            pd_s3_r <= pd_s2_r;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            last_bank_r <= 3'h0;
            last_wr_r   <= 1'b0;
            bursting_r  <= 1'b0;
            resetting_r <= 1'b0;
        end
        else
        begin
            if (take && (req.cmd == LPCB_RD || req.cmd == LPCB_WR))
            begin
                last_bank_r <= req.bank;
                last_wr_r   <= req.cmd == LPCB_WR;
            end
            bursting_r  <= any_burst;
            if (take && req.cmd == LPCB_RST)
                resetting_r <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_cmd      <= LPCB_NOP;
            mem_bank     <= 3'h0;
            mem_auto_pre <= 1'b0;
            mem_row      <= 15'h0;
            mem_col      <= 10'h0;
            mem_mr       <= 16'h0;
            mem_cke      <= 1'b0;
            mem_dq_o     <= 32'h0;
            mem_dm       <= 4'hf;
        end
        else
        begin
            mem_cmd      <= take ? req.cmd : LPCB_NOP;
            mem_bank     <= req.bank;
            mem_auto_pre <= req.auto_pre;
            mem_row      <= req.row;
            mem_col      <= req.col;
            mem_mr       <= {req.mr_addr, req.mr_data};
            mem_cke      <= pd_s2_r;
            mem_dq_o     <= wbeat.data;
            mem_dm       <= wbeat.mask;
        end
    end

    property p_mrr_quiet;
        @(posedge core_clk) disable iff (!arst_n)
        (take && req.cmd == LPCB_MRR) |=> !req_ready [*2];
    endproperty
    a_mrr_quiet: assert property (p_mrr_quiet) else $error("command during mrr");

    property p_rrd;
        @(posedge core_clk) disable iff (!arst_n)
        (take && req.cmd == LPCB_ACT) |=> !(take && req.cmd == LPCB_ACT) [*2];
    endproperty
    a_rrd: assert property (p_rrd) else $error("activate spacing broken");

    property p_mrw_idle;
        @(posedge core_clk) disable iff (!arst_n)
        (take && (req.cmd == LPCB_MRW || req.cmd == LPCB_REF)) |-> all_idle;
    endproperty
    a_mrw_idle: assert property (p_mrw_idle) else $error("mrw with busy bank");

    property p_bst;
        @(posedge core_clk) disable iff (!arst_n)
        (take && req.cmd == LPCB_BST) |-> any_burst;
    endproperty
    a_bst: assert property (p_bst) else $error("bst without burst");

    property p_issue;
        @(posedge core_clk) disable iff (!arst_n)
        take |=> mem_cmd == $past(req.cmd) && mem_cke;
    endproperty
    a_issue: assert property (p_issue) else $error("command not driven");

    property p_mask;
        @(posedge core_clk) disable iff (!arst_n)
        1'b1 |=> mem_dm == $past(wbeat.mask);
    endproperty
    a_mask: assert property (p_mask) else $error("mask not forwarded");

    property p_rw_active;
        @(posedge core_clk) disable iff (!arst_n)
        (take && (req.cmd == LPCB_RD || req.cmd == LPCB_WR)) |-> tgt == LPCB_B_ACTV;
    endproperty
    a_rw_active: assert property (p_rw_active) else $error("access to unopened bank");

    property p_pdx;
        @(posedge core_clk) disable iff (!arst_n)
        $rose(pd_s2_r) |-> !req_ready [*2];
    endproperty
    a_pdx: assert property (p_pdx) else $error("command inside exit time");

    property p_rst_mrr;
        @(posedge core_clk) disable iff (!arst_n)
        (resetting_r && req_valid && req.cmd == LPCB_MRR && quiet && pd_s2_r && pd_s3_r)
            |-> req_ready;
    endproperty
    a_rst_mrr: assert property (p_rst_mrr) else $error("mrr refused while resetting");
endmodule : lpcb_ctrl

// ### lpcb_mem_model.sv
`timescale 1ns/1ps
`include "lpcb_defs.svh"
module lpcb_mem_model
    import lpcb_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    input  lpcb_cmd_t       mem_cmd,
    input  wire logic [2:0] mem_bank,
    input  wire logic       mem_auto_pre,
    input  wire logic       mem_cke,
    output logic [7:0]      viol_cnt
);
    localparam int TRCD = `LPCB_CYC_UP(`LPCB_TRCD_NS);
    localparam int TRP  = `LPCB_CYC_UP(`LPCB_TRP_NS);
    localparam int TRRD = `LPCB_CYC_UP(`LPCB_TRRD_NS);
    localparam int TRFC = `LPCB_CYC_UP(`LPCB_TRFC_NS);
    lpcb_bank_t st_r [8];
    int         tmr_r [8];
    logic       ap_r [8];
    int         rrd_r;
    int         busy_r;
    logic [2:0] last_r;
    logic       last_wr;
    logic       idle;
    logic       burst;
    always @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            foreach (st_r[i]) st_r[i] = LPCB_B_IDLE;
            foreach (tmr_r[i]) tmr_r[i] = 0;
            viol_cnt = 8'h00;
            rrd_r = 0;
            busy_r = 0;
            last_r = 3'h0;
            last_wr = 1'b0;
        end
        else
        begin
            // timers expire before the command is judged, so an edge that meets tRCD is legal
            rrd_r -= (rrd_r > 0);
            busy_r -= (busy_r > 0);
            foreach (tmr_r[i]) tmr_r[i] -= (tmr_r[i] > 0);
            foreach (st_r[i])
                if (tmr_r[i] == 0 && st_r[i] != LPCB_B_IDLE && st_r[i] != LPCB_B_ACTV)
                begin
                    if (st_r[i] == LPCB_B_BURST && ap_r[i])
                    begin
                        st_r[i] = LPCB_B_PRE;
                        tmr_r[i] = TRP;
                    end
                    else
                        st_r[i] = (st_r[i] == LPCB_B_PRE) ? LPCB_B_IDLE : LPCB_B_ACTV;
                end
            idle = 1'b1;
            burst = 1'b0;
            foreach (st_r[i])
            begin
                idle &= (st_r[i] == LPCB_B_IDLE);
                burst |= (st_r[i] == LPCB_B_BURST);
            end
            if (mem_cmd != LPCB_NOP && (!mem_cke || busy_r > 0)) viol_cnt++;
            case (mem_cmd)
                LPCB_ACT:
                begin
                    if (st_r[mem_bank] != LPCB_B_IDLE || rrd_r > 0) viol_cnt++;
                    st_r[mem_bank] = LPCB_B_OPEN;
                    tmr_r[mem_bank] = TRCD;
                    rrd_r = TRRD;
                end
                LPCB_RD, LPCB_WR:
                begin
                    if (st_r[mem_bank] != LPCB_B_ACTV) viol_cnt++;
                    if (burst && ((mem_cmd == LPCB_WR) != last_wr)) viol_cnt++;
                    last_wr = (mem_cmd == LPCB_WR);
                    st_r[mem_bank] = LPCB_B_BURST;
                    tmr_r[mem_bank] = `LPCB_BURST_CK;
                    ap_r[mem_bank] = mem_auto_pre;
                    last_r = mem_bank;
                end
                LPCB_PRE:
                begin
                    st_r[mem_bank] = LPCB_B_PRE;
                    tmr_r[mem_bank] = TRP;
                end
                LPCB_PREA:
                begin
                    if (burst) viol_cnt++;
                    foreach (st_r[i]) st_r[i] = LPCB_B_PRE;
                    foreach (tmr_r[i]) tmr_r[i] = TRP;
                end
                LPCB_BST:
                begin
                    if (st_r[mem_bank] != LPCB_B_BURST || mem_bank != last_r) viol_cnt++;
                    st_r[mem_bank] = LPCB_B_ACTV;
                    tmr_r[mem_bank] = 0;
                end
                LPCB_MRR:
                begin
                    if (burst) viol_cnt++;
                    busy_r = `LPCB_TMRR_CK;
                end
                LPCB_MRW, LPCB_RST, LPCB_REF, LPCB_SRE:
                begin
                    if (!idle) viol_cnt++;
                    busy_r = (mem_cmd == LPCB_REF) ? TRFC : `LPCB_TMRW_CK;
                end
                default: ;
            endcase
        end
    end
endmodule : lpcb_mem_model

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import lpcb_pkg::*;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    lpcb_req_t   req = '0;
    logic        req_valid = 1'b0;
    logic        req_ready;
    logic        req_illegal;
    lpcb_wbeat_t wbeat = '0;
    logic        pd_exit = 1'b0;
    lpcb_cmd_t   mem_cmd;
    logic [2:0]  mem_bank;
    logic        mem_auto_pre;
    logic        mem_cke;
    logic [31:0] mem_dq_o;
    logic [3:0]  mem_dm;
    logic [14:0] mem_row;
    logic [9:0]  mem_col;
    logic [15:0] mem_mr;
    logic [7:0]  viol_cnt;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          n;
    lpcb_ctrl dut_u (.core_clk(core_clk), .arst_n(arst_n), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .req_illegal(req_illegal), .wbeat(wbeat), .pd_exit(pd_exit),
        .mem_cmd(mem_cmd), .mem_bank(mem_bank), .mem_auto_pre(mem_auto_pre),
        .mem_row(mem_row), .mem_col(mem_col), .mem_mr(mem_mr), .mem_cke(mem_cke),
        .mem_dq_o(mem_dq_o), .mem_dm(mem_dm));
    lpcb_mem_model mem_u (.core_clk(core_clk), .arst_n(arst_n), .mem_cmd(mem_cmd),
        .mem_bank(mem_bank), .mem_auto_pre(mem_auto_pre), .mem_cke(mem_cke),
        .viol_cnt(viol_cnt));
    initial forever #2.5 core_clk = ~core_clk;
    task automatic test_done;
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            mismatches++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic put(input lpcb_cmd_t c, input logic [2:0] b, input logic ap);
        req <= '{cmd: c, bank: b, auto_pre: ap, row: 15'h0012, col: 10'h004,
                 mr_addr: 8'h01, mr_data: 8'h5a};
        req_valid <= 1'b1;
    endtask : put
    // holds the request until ready is seen, then checks the one-cycle command
    task automatic send(input lpcb_cmd_t c, input logic [2:0] b, input logic ap, output int w);
        w = 0;
        put(c, b, ap);
        do
        begin
            @(negedge core_clk);
            w++;
        end while (req_ready !== 1'b1 && w < 64);
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(negedge core_clk);
        chk("mem_cmd", 32'(c), 32'(mem_cmd));
        chk("mem_bank", 32'(b), 32'(mem_bank));
        chk("mem_auto_pre", 32'(ap), 32'(mem_auto_pre));
        chk("mem_row", 32'h12, 32'(mem_row));
        chk("mem_col", 32'h4, 32'(mem_col));
        chk("mem_mr", 32'h015a, 32'(mem_mr));
        @(posedge core_clk);
    endtask : send
    task automatic refuse(input lpcb_cmd_t c, input logic [2:0] b);
        put(c, b, 1'b0);
        @(negedge core_clk);
        chk("req_illegal", 32'h1, 32'(req_illegal));
        chk("req_ready", 32'h0, 32'(req_ready));
        @(posedge core_clk);
        req_valid <= 1'b0;
        @(posedge core_clk);
    endtask : refuse
    task automatic t_reset;
        chk("mem_cmd", 32'(LPCB_NOP), 32'(mem_cmd));
        chk("mem_cke", 32'h0, 32'(mem_cke));
        chk("mem_dm", 32'hf, 32'(mem_dm));
    endtask : t_reset
    task automatic t_cross;
        send(LPCB_ACT, 3'h0, 1'b0, n);
        send(LPCB_ACT, 3'h1, 1'b0, n);
        chk("act_gap_ok", 32'h1, 32'(n >= 2));
        send(LPCB_MRR, 3'h1, 1'b0, n);
        send(LPCB_RD, 3'h0, 1'b1, n);
        refuse(LPCB_WR, 3'h1);
        send(LPCB_ACT, 3'h2, 1'b0, n);
        send(LPCB_WR, 3'h1, 1'b0, n);
        refuse(LPCB_RD, 3'h2);
        send(LPCB_RD, 3'h2, 1'b0, n);
    endtask : t_cross
    task automatic t_refuse;
        repeat (12) @(posedge core_clk);
        refuse(LPCB_MRW, 3'h0);
        refuse(LPCB_REF, 3'h0);
        refuse(LPCB_BST, 3'h3);
        send(LPCB_PRE, 3'h1, 1'b0, n);
    endtask : t_refuse
    task automatic t_allidle;
        send(LPCB_PREA, 3'h0, 1'b0, n);
        send(LPCB_MRW, 3'h0, 1'b0, n);
        send(LPCB_REF, 3'h0, 1'b0, n);
        send(LPCB_RST, 3'h0, 1'b0, n);
        send(LPCB_MRR, 3'h0, 1'b0, n);
    endtask : t_allidle
    task automatic t_mask;
        wbeat <= '{data: 32'ha5a5_0f0f, mask: 4'h6};
        @(posedge core_clk);
        @(negedge core_clk);
        chk("mem_dm", 32'h6, 32'(mem_dm));
        chk("mem_dq_o", 32'ha5a5_0f0f, mem_dq_o);
        @(posedge core_clk);
    endtask : t_mask
    initial
    begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        t_reset();
        @(posedge core_clk);
        pd_exit <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk("mem_cke", 32'h1, 32'(mem_cke));
        t_cross();
        t_refuse();
        t_allidle();
        t_mask();
        repeat (4) @(posedge core_clk);
        chk("viol_cnt", 32'h0, 32'(viol_cnt));
        test_done();
    end
endmodule : tb_top
